/* File: logic/osc_pkg.sv */
package osc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OSC_MODULATOR_RATE_CONFIG_OFS = 8'h0E;
  localparam logic [7:0] OSC_CHANNEL_POWER_CONTROL_OFS = 8'h0F;
  localparam logic [7:0] OSC_MODULATOR_RATE_CONFIG_RST = 8'h86;
  localparam logic [7:0] OSC_CHANNEL_POWER_CONTROL_RST = 8'h00;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int OSC_RATIO_SEL_LSB  = 0;
  localparam int OSC_RATIO_SEL_W    = 4;
  localparam int OSC_POWER_ON_LSB   = 0;
  localparam int OSC_POWER_ON_W     = 4;
  localparam logic [3:0] OSC_POWER_ALL_OFF = 4'h0;
  localparam logic [3:0] OSC_POWER_ALL_ON  = 4'hF;

  localparam int OSC_RATIO_W = 13;

  // Decimation ratio for each selection code
  function automatic logic [12:0] osc_ratio_of(input logic [3:0] sel);
    logic [12:0] r;
    r = 13'h0000;
    unique case (sel)
      4'h0: r = 13'd4096;
      4'h1: r = 13'd2048;
      4'h2: r = 13'd1024;
      4'h3: r = 13'd800;
      4'h4: r = 13'd768;
      4'h5: r = 13'd512;
      4'h6: r = 13'd400;
      4'h7: r = 13'd384;
      4'h8: r = 13'd256;
      4'h9: r = 13'd200;
      4'hA: r = 13'd192;
      4'hB: r = 13'd128;
      4'hC: r = 13'd96;
      4'hD: r = 13'd64;
      4'hE: r = 13'd48;
      4'hF: r = 13'd32;
    endcase
    return r;
  endfunction : osc_ratio_of

endpackage : osc_pkg

/* File: logic/osc_decim_timer.sv */
`timescale 1ns/10ps
module osc_decim_timer
  import osc_pkg::*;
#(
  parameter int RATIO_W = OSC_RATIO_W
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               run,
  input  wire logic [RATIO_W-1:0] ratio,
  output logic                    sample_strobe
);

  logic [RATIO_W-1:0] count_r;

  // ---------------------------------------------------------------
  // Modulator clock counter
  // ---------------------------------------------------------------
  // Restarts when stopped so the first sample after power-up takes a full ratio
  always_ff @(posedge clk)
  begin
    if (rst || !run)
      count_r <= '0;
    else if (count_r >= ratio - RATIO_W'(1))
      count_r <= '0;
    else
      count_r <= count_r + RATIO_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst || !run)
      sample_strobe <= 1'b0;
    else
      sample_strobe <= (count_r >= ratio - RATIO_W'(1));
  end

endmodule : osc_decim_timer

/* File: logic/osc_cfg.sv */
`timescale 1ns/10ps
module osc_cfg
  import osc_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  output logic      [OSC_RATIO_SEL_W-1:0] decimation_ratio_sel,
  output logic      [OSC_RATIO_W-1:0]    decimation_ratio,
  output logic      [CHANNELS-1:0]       channel_power_on,
  output logic                           sample_strobe
);

  logic [7:0] modulator_rate_config_r;
  logic [7:0] channel_power_control_r;
  logic       all_on;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Whole bytes are kept so reserved bits read back as written
  always_ff @(posedge clk)
  begin
    if (rst)
      modulator_rate_config_r <= OSC_MODULATOR_RATE_CONFIG_RST;
    else if (reg_wr && reg_addr == OSC_MODULATOR_RATE_CONFIG_OFS)
      modulator_rate_config_r <= reg_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      channel_power_control_r <= OSC_CHANNEL_POWER_CONTROL_RST;
    else if (reg_wr && reg_addr == OSC_CHANNEL_POWER_CONTROL_OFS)
      channel_power_control_r <= reg_wdata;
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        OSC_MODULATOR_RATE_CONFIG_OFS: reg_rdata <= modulator_rate_config_r;
        OSC_CHANNEL_POWER_CONTROL_OFS: reg_rdata <= channel_power_control_r;
        default:                       reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ---------------------------------------------------------------
  // Channel power and rate
  // ---------------------------------------------------------------
  // Forbidden patterns are treated as off: only all ones powers up, a
  // safe choice since the host must not write anything else
  assign all_on = channel_power_control_r[OSC_POWER_ON_LSB +: OSC_POWER_ON_W]
                  == OSC_POWER_ALL_ON;

  always_ff @(posedge clk)
  begin
    if (rst)
      channel_power_on <= '0;
    else
      channel_power_on <= {CHANNELS{all_on}};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      decimation_ratio_sel <= OSC_MODULATOR_RATE_CONFIG_RST[OSC_RATIO_SEL_LSB +: OSC_RATIO_SEL_W];
    else
      decimation_ratio_sel <=
        modulator_rate_config_r[OSC_RATIO_SEL_LSB +: OSC_RATIO_SEL_W];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      decimation_ratio <= osc_ratio_of(OSC_MODULATOR_RATE_CONFIG_RST[3:0]);
    else
      decimation_ratio <= osc_ratio_of(decimation_ratio_sel);
  end

  // No conversions while powered down
  osc_decim_timer #(
    .RATIO_W (OSC_RATIO_W)
  ) u_timer (
    .clk           (clk),
    .rst           (rst),
    .run           (channel_power_on[0]),
    .ratio         (decimation_ratio),
    .sample_strobe (sample_strobe)
  );

endmodule : osc_cfg

/* File: sim/osc_host.sv */
`timescale 1ns/10ps
module osc_host (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // The strobe stands for one cycle and drops on the next edge, with no spare edge after it
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
  endtask : wr
  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask : rd
endmodule : osc_host

/* File: sim/osc_cfg_monitor.sv */
`timescale 1ns/10ps
module osc_cfg_monitor
  import osc_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic [3:0]          decimation_ratio_sel,
  input wire logic [CHANNELS-1:0] channel_power_on,
  input wire logic                sample_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wr_rate = reg_wr && reg_addr == 8'h0E;
  wire wr_pwr  = reg_wr && reg_addr == 8'h0F;
  a_sel_reset: assert property ($fell(rst) |-> decimation_ratio_sel == 4'h6)
    else $error("sel reset");
  a_sel_write: assert property (wr_rate ##1 !wr_rate |=>
    decimation_ratio_sel == $past(reg_wdata[3:0], 2)) else $error("sel write");
  a_pwr_reset: assert property ($fell(rst) |-> channel_power_on == '0)
    else $error("power reset");
  a_pwr_up: assert property (wr_pwr && reg_wdata[3:0] == 4'hF ##1 !wr_pwr |=>
    &channel_power_on) else $error("power up");
  a_pwr_down: assert property (wr_pwr && reg_wdata[3:0] == 4'h0 ##1 !wr_pwr |=>
    channel_power_on == '0) else $error("power down");
  a_pwr_global: assert property (channel_power_on == '0 || &channel_power_on)
    else $error("power split");
  a_off_quiet: assert property (!channel_power_on[0] && !$past(channel_power_on[0])
    |-> !sample_strobe) else $error("strobe while off");
  a_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
    else $error("strobe width");
  a_read_unmap: assert property (reg_rd && reg_addr > 8'h0F |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  c_strobe: cover property (sample_strobe);
  c_power: cover property (&channel_power_on);
  c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule : osc_cfg_monitor

/* File: sim/osc_cfg_tb.sv */
`timescale 1ns/10ps
module osc_cfg_tb;
  import osc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, reg_wr, reg_rd, sample_strobe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, q;
  logic [3:0] decimation_ratio_sel, channel_power_on;
  logic [12:0] decimation_ratio;
  int fails = 0, checks_done = 0, n;
  int ratio_tab[16] = '{4096, 2048, 1024, 800, 768, 512, 400, 384, 256, 200, 192, 128, 96, 64, 48, 32};
  osc_cfg dut (.*);
  osc_host host (.*);
  always #2 clk = ~clk;
  task automatic chk(input string s, input logic [12:0] e, input logic [12:0] g);
    checks_done++;
    if (g !== e) begin fails++; $display("Error %s expected %0h seen %0h", s, e, g); end
  endtask : chk
  // Counts cycles up to the next strobe; capped so a silent timer cannot hang
  task automatic gap(output int c);
    c = 0;
    do begin @(negedge clk); c++; end while (!sample_strobe && c < 5000);
  endtask : gap
  task automatic conclude;
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin #240000; fails++; conclude(); end
  initial begin
    void'($urandom(72918));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    host.rd(8'h0E, q); chk("rate reg", 8'h86, q);
    host.rd(8'h0F, q); chk("power reg", 8'h00, q);
    chk("sel", 4'h6, decimation_ratio_sel);
    host.wr(8'h0F, 8'h0F);
    // Register lands on the strobe edge, the power outputs one edge later
    repeat (2) @(negedge clk);
    chk("power on", 4'hF, channel_power_on);
    for (int i = 0; i < 16; i++) begin
      d = {4'($urandom()), i[3:0]};
      host.wr(8'h0E, d);
      host.rd(8'h0E, q); chk("rate readback", d, q);
      chk("sel", i, decimation_ratio_sel);
      chk("ratio", ratio_tab[i], decimation_ratio);
      gap(n);
      gap(n); chk("period", ratio_tab[i], n);
    end
    host.wr(8'h0F, 8'h00);
    repeat (2) @(negedge clk);
    chk("power off", 4'h0, channel_power_on);
    gap(n); chk("idle cycles", 5000, n);
    d = 8'($urandom_range(255, 16));
    host.wr(d, 8'($urandom()));
    host.rd(d, q); chk("unmapped", 8'h00, q);
    conclude();
  end
endmodule : osc_cfg_tb
bind osc_cfg osc_cfg_monitor #(.CHANNELS(CHANNELS)) u_mon (.*);
